// file: lcdid_defs.svh
`ifndef LCDID_DEFS_SVH
`define LCDID_DEFS_SVH

// instruction encodings and fields
`define LCDID_CMD_CLEAR 8'h01
`define LCDID_CMD_HOME 7'h01
`define LCDID_CMD_ENTRY 6'h01
`define LCDID_CMD_DISP 5'h01
`define LCDID_CMD_SHIFT 4'h1
`define LCDID_CMD_FUNC 3'h1
`define LCDID_CMD_GADDR 2'h1
`define LCDID_BIT_DADDR 7
`define LCDID_BIT_ID 1
`define LCDID_BIT_S 0
`define LCDID_BIT_D 2
`define LCDID_BIT_C 1
`define LCDID_BIT_B 0
`define LCDID_BIT_SC 3
`define LCDID_BIT_RL 2

// display address map per line pair
`define LCDID_LINE1_END 7'h27
`define LCDID_LINE2_BEG 7'h40
`define LCDID_LINE2_END 7'h67
`define LCDID_LINE1_BEG 7'h00
`define LCDID_SHIFT_MAX 6'h27
`define LCDID_BLANK 8'h20
`define LCDID_FILL_LAST 8'hff

// reset values
`define LCDID_RST_ENTRY_ID 1'b1
`define LCDID_RST_ENTRY_S 1'b0

// timing
`define LCDID_CLK_NS 50
`define LCDID_T_CMD_NS 40000
`define LCDID_T_HOME_NS 1600000
`define LCDID_T_BLINK_NS 400000000
`define LCDID_CMD_CYC ((`LCDID_T_CMD_NS + `LCDID_CLK_NS - 1) / `LCDID_CLK_NS)
`define LCDID_HOME_CYC ((`LCDID_T_HOME_NS + `LCDID_CLK_NS - 1) / `LCDID_CLK_NS)
`define LCDID_BLINK_CYC (`LCDID_T_BLINK_NS / `LCDID_CLK_NS)

`endif

// file: lcdid_pkg.sv
package lcdid_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_CLEAR} lcdid_state_t;
  typedef logic [6:0] lcdid_addr_t;
  typedef logic [7:0] lcdid_byte_t;
endpackage

// file: lcdid_ram_if.sv
interface lcdid_ram_if;
  logic wr_en;
  logic glyph_sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output wr_en, output glyph_sel, output addr, output wdata, input rdata);
  modport mem (input wr_en, input glyph_sel, input addr, input wdata, output rdata);
endinterface

// file: lcdid_ram.sv
module lcdid_ram
  import lcdid_pkg::*;
(
  input wire logic clk_i,
  lcdid_ram_if.mem ram
);
  logic [7:0] disp_mem [0:255];
  logic [7:0] glyph_mem [0:63];

  always_ff @(posedge clk_i)
  begin
    if (ram.wr_en && !ram.glyph_sel)
    begin
      disp_mem[ram.addr] <= ram.wdata;
    end
    if (ram.wr_en && ram.glyph_sel)
    begin
      glyph_mem[ram.addr[5:0]] <= ram.wdata;
    end
  end

  assign ram.rdata = ram.glyph_sel ? glyph_mem[ram.addr[5:0]] : disp_mem[ram.addr];
endmodule // lcdid_ram

// file: lcdid_blink.sv
`include "lcdid_defs.svh"
module lcdid_blink
  import lcdid_pkg::*;
#(
  parameter int unsigned BLINK_CYC = `LCDID_BLINK_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  output logic dark_o
);
  logic [22:0] cnt_r;
  localparam logic [22:0] LAST = 23'(BLINK_CYC - 1);

  // blink phase flips every interval
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !enable_i)
    begin
      cnt_r <= 23'h0;
      dark_o <= 1'b0;
    end
    else if (cnt_r == LAST)
    begin
      cnt_r <= 23'h0;
      dark_o <= !dark_o;
    end
    else
    begin
      cnt_r <= cnt_r + 23'h1;
    end
  end

  blink_period_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enable_i && cnt_r == LAST && $past(enable_i)) |=> (dark_o != $past(dark_o)))
    else $error("blink phase did not flip at interval end");
endmodule // lcdid_blink

// file: lcdid_decoder.sv
`include "lcdid_defs.svh"
module lcdid_decoder
  import lcdid_pkg::*;
#(
  parameter int unsigned HOME_CYC = `LCDID_HOME_CYC,
  parameter int unsigned BLINK_CYC = `LCDID_BLINK_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic register_select_i,
  input wire logic read_not_write_i,
  input wire logic strobe_i,
  input wire logic second_strobe_i,
  input wire logic four_line_i,
  input wire logic [7:0] parallel_bus_i,
  output logic [7:0] parallel_bus_o,
  output logic parallel_bus_oe_o,
  output logic busy_flag_o,
  output logic [6:0] address_pointer_o,
  output logic glyph_sel_o,
  output logic upper_pair_o,
  output logic [5:0] shift_offset_o,
  output logic display_on_o,
  output logic cursor_on_o,
  output logic blink_on_o,
  output logic blink_dark_o
);
  localparam logic [14:0] CMD_CYC = 15'(`LCDID_CMD_CYC);
  localparam logic [14:0] HOME_LAST = 15'(HOME_CYC - 1);

  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  logic strb_prev_r;
  logic pair_r;
  lcdid_state_t state_r;
  logic [14:0] busy_cnt_r;
  logic [7:0] fill_idx_r;
  logic fill_done_r;
  logic [7:0] instruction_latch_r;
  logic [7:0] data_latch_r;
  logic entry_id_r;
  logic entry_s_r;
  logic [6:0] ptr_nxt;

  wire logic rs = sync2_r[11];
  wire logic rd = sync2_r[10];
  wire logic strb = sync2_r[9] | sync2_r[8];
  wire logic [7:0] bus_d = sync2_r[7:0];
  wire logic strb_fall = strb_prev_r & ~strb;
  wire logic strb_rise = ~strb_prev_r & strb;
  wire logic accept = strb_fall & ~rd & (state_r == ST_IDLE);
  wire logic cmd_wr = accept & ~rs;
  wire logic data_wr = accept & rs;
  wire logic data_rd = strb_fall & rd & rs & (state_r == ST_IDLE);
  wire logic is_clear = (bus_d == `LCDID_CMD_CLEAR);
  wire logic is_home = (bus_d[7:1] == `LCDID_CMD_HOME);
  wire logic is_entry = (bus_d[7:2] == `LCDID_CMD_ENTRY);
  wire logic is_disp = (bus_d[7:3] == `LCDID_CMD_DISP);
  wire logic is_shift = (bus_d[7:4] == `LCDID_CMD_SHIFT);
  wire logic is_gaddr = (bus_d[7:6] == `LCDID_CMD_GADDR);
  wire logic is_daddr = bus_d[`LCDID_BIT_DADDR];

  lcdid_ram_if ram_bus ();

  lcdid_ram u_ram (
    .clk_i(clk_i),
    .ram(ram_bus.mem)
  );

  lcdid_blink #(.BLINK_CYC(BLINK_CYC)) u_blink (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(blink_on_o),
    .dark_o(blink_dark_o)
  );

  // pointer wrap inside a line pair
  function automatic logic [6:0] step_ptr(input logic [6:0] a, input logic up, input logic glyph);
    logic [6:0] r;
    r = up ? a + 7'h1 : a - 7'h1;
    if (glyph)
      r = {1'b0, r[5:0]};
    else if (up && a == `LCDID_LINE1_END)
      r = `LCDID_LINE2_BEG;
    else if (up && a == `LCDID_LINE2_END)
      r = `LCDID_LINE1_BEG;
    else if (!up && a == `LCDID_LINE2_BEG)
      r = `LCDID_LINE1_END;
    else if (!up && a == `LCDID_LINE1_BEG)
      r = `LCDID_LINE2_END;
    return r;
  endfunction

  // shift offset modulo line length, both lines of a pair together
  function automatic logic [5:0] step_shift(input logic [5:0] o, input logic left);
    logic [5:0] r;
    if (left)
      r = (o == `LCDID_SHIFT_MAX) ? 6'h0 : o + 6'h1;
    else
      r = (o == 6'h0) ? `LCDID_SHIFT_MAX : o - 6'h1;
    return r;
  endfunction

  // pin synchroniser
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_r <= 12'h0;
      sync2_r <= 12'h0;
      strb_prev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {register_select_i, read_not_write_i, strobe_i, second_strobe_i,
                  parallel_bus_i};
      sync2_r <= sync1_r;
      strb_prev_r <= strb;
    end
  end

  // which controller half the strobe addresses
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      pair_r <= 1'b0;
    else if (strb_rise)
      pair_r <= sync2_r[8] & four_line_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      instruction_latch_r <= 8'h0;
      data_latch_r <= 8'h0;
    end
    else if (cmd_wr)
      instruction_latch_r <= bus_d;
    else if (data_wr)
      data_latch_r <= bus_d;
    else if (strb_rise && rd && rs)
      data_latch_r <= ram_bus.rdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_IDLE;
      busy_cnt_r <= 15'h0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (cmd_wr && (is_clear || is_home))
          begin
            state_r <= is_clear ? ST_CLEAR : ST_BUSY;
            busy_cnt_r <= HOME_LAST;
          end
          else if (accept || data_rd)
          begin
            state_r <= ST_BUSY;
            busy_cnt_r <= CMD_CYC - 15'h1;
          end
        end
        ST_BUSY, ST_CLEAR:
        begin
          // clear also waits for the fill to reach the last location
          if (busy_cnt_r != 15'h0)
            busy_cnt_r <= busy_cnt_r - 15'h1;
          else if (state_r == ST_BUSY || fill_done_r)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // clear fills the whole display memory with blanks
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || state_r != ST_CLEAR)
    begin
      fill_idx_r <= 8'h0;
      fill_done_r <= 1'b0;
    end
    else if (!fill_done_r)
    begin
      fill_idx_r <= fill_idx_r + 8'h1;
      fill_done_r <= (fill_idx_r == `LCDID_FILL_LAST);
    end
  end

  // ram port; shift command never writes
  always_comb
  begin
    ram_bus.wr_en = 1'b0;
    ram_bus.glyph_sel = glyph_sel_o;
    ram_bus.addr = glyph_sel_o ? {2'b00, address_pointer_o[5:0]} : {pair_r, address_pointer_o};
    ram_bus.wdata = data_latch_r;
    if (state_r == ST_CLEAR && !fill_done_r)
    begin
      ram_bus.wr_en = 1'b1;
      ram_bus.glyph_sel = 1'b0;
      ram_bus.addr = fill_idx_r;
      ram_bus.wdata = `LCDID_BLANK;
    end
    else if (data_wr)
    begin
      ram_bus.wr_en = 1'b1;
      ram_bus.wdata = bus_d;
    end
  end

  // address set, stepping, home, cursor move
  always_comb
  begin
    ptr_nxt = address_pointer_o;
    if (cmd_wr && (is_clear || is_home))
      ptr_nxt = 7'h0;
    else if (cmd_wr && is_daddr)
      ptr_nxt = bus_d[6:0];
    else if (cmd_wr && is_gaddr)
      ptr_nxt = {1'b0, bus_d[5:0]};
    else if (cmd_wr && is_shift)
      ptr_nxt = step_ptr(address_pointer_o, bus_d[`LCDID_BIT_RL], glyph_sel_o);
    else if (data_wr || data_rd)
      ptr_nxt = step_ptr(address_pointer_o, entry_id_r, glyph_sel_o);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      address_pointer_o <= 7'h0;
      glyph_sel_o <= 1'b0;
      upper_pair_o <= 1'b0;
    end
    else
    begin
      address_pointer_o <= ptr_nxt;
      if (cmd_wr && (is_clear || is_home || is_daddr))
        glyph_sel_o <= 1'b0;
      else if (cmd_wr && is_gaddr)
        glyph_sel_o <= 1'b1;
      // clear on second strobe homes to line 3 when four_line_i is set
      if (cmd_wr && is_clear)
        upper_pair_o <= pair_r;
    end
  end

  // entry shift on writes only, offset wraps within pair
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      shift_offset_o <= 6'h0;
    else if (cmd_wr && (is_clear || is_home))
      shift_offset_o <= 6'h0;
    else if (cmd_wr && is_shift && bus_d[`LCDID_BIT_SC])
      shift_offset_o <= step_shift(shift_offset_o, !bus_d[`LCDID_BIT_RL]);
    else if (data_wr && entry_s_r && !glyph_sel_o)
      shift_offset_o <= step_shift(shift_offset_o, entry_id_r);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      entry_id_r <= `LCDID_RST_ENTRY_ID;
      entry_s_r <= `LCDID_RST_ENTRY_S;
      display_on_o <= 1'b0;
      cursor_on_o <= 1'b0;
      blink_on_o <= 1'b0;
    end
    else if (cmd_wr && is_entry)
    begin
      entry_id_r <= bus_d[`LCDID_BIT_ID];
      entry_s_r <= bus_d[`LCDID_BIT_S];
    end
    else if (cmd_wr && is_disp)
    begin
      display_on_o <= bus_d[`LCDID_BIT_D];
      cursor_on_o <= bus_d[`LCDID_BIT_C];
      blink_on_o <= bus_d[`LCDID_BIT_B];
    end
  end

  // read answers while strobe is high
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      parallel_bus_o <= 8'h0;
      parallel_bus_oe_o <= 1'b0;
      busy_flag_o <= 1'b0;
    end
    else
    begin
      busy_flag_o <= (state_r != ST_IDLE);
      parallel_bus_oe_o <= strb & rd;
      if (strb_rise && rd && !rs)
        parallel_bus_o <= {state_r != ST_IDLE, address_pointer_o};
      else if (strb_rise && rd && rs)
        parallel_bus_o <= ram_bus.rdata;
    end
  end

  cmd_busy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_wr |=> ##1 busy_flag_o)
    else $error("command write did not raise busy");

  // ordinary command holds busy for full time
  busy_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_wr && is_entry) |=> (state_r == ST_BUSY && busy_cnt_r == CMD_CYC - 15'h1))
    else $error("ordinary command busy time wrong");

  // status byte carries busy and pointer
  status_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (strb_rise && rd && !rs) |=> parallel_bus_o == {$past(state_r) != ST_IDLE,
                                                   $past(address_pointer_o)})
    else $error("status byte mismatch");

  addr_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_wr && is_daddr) |=> (address_pointer_o == $past(bus_d[6:0]) && !glyph_sel_o))
    else $error("address set not copied");

  home_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_wr && is_home) |=> (address_pointer_o == 7'h0 && shift_offset_o == 6'h0))
    else $error("home did not zero pointer and shift");

  // line wrap from end of line 1
  line_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (data_wr && entry_id_r && !glyph_sel_o && address_pointer_o == `LCDID_LINE1_END)
    |=> address_pointer_o == `LCDID_LINE2_BEG)
    else $error("pointer did not wrap to line 2");

  read_noshift_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    data_rd |=> $stable(shift_offset_o))
    else $error("read shifted the display");

  // shift offset stays within a line
  shift_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    shift_offset_o <= `LCDID_SHIFT_MAX)
    else $error("shift offset beyond line length");

  busy_refuse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r != ST_IDLE) |-> !ram_bus.wr_en || state_r == ST_CLEAR)
    else $error("write accepted while busy");
endmodule // lcdid_decoder

// file: lcdid_host.sv
module lcdid_host
  import lcdid_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  output logic register_select_o,
  output logic read_not_write_o,
  output logic strobe_o,
  output logic second_strobe_o,
  output logic [7:0] bus_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // 1 = talk through the controller of lines 3/4
  logic use_second = 1'b0;

  initial
  begin
    register_select_o = 1'b0;
    read_not_write_o = 1'b1;
    strobe_o = 1'b0;
    second_strobe_o = 1'b0;
    bus_o = 8'h00;
  end

  task automatic access(input logic rs, input logic rw, input lcdid_byte_t d,
                        output lcdid_byte_t q);
    @(posedge clk_i);
    #2;
    register_select_o = rs;
    read_not_write_o = rw;
    // released bus shows inverted last value
    bus_o = rw ? ~bus_o : d;
    @(posedge clk_i);
    #2;
    strobe_o = !use_second;
    second_strobe_o = use_second;
    repeat (6) @(posedge clk_i);
    #2;
    q = bus_i;
    strobe_o = 1'b0;
    second_strobe_o = 1'b0;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic cmd(input logic rs, input logic rw, input lcdid_byte_t d,
                     output lcdid_byte_t q, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++)
    begin
      access(1'b0, 1'b1, 8'h00, q);
      ok = (q[7] === 1'b0);
    end
    if (ok)
      access(rs, rw, d, q);
  endtask
endmodule // lcdid_host

// file: tb.sv
`define CHK(g, e) check_eq(8'(g), 8'(e));
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lcdid_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rs;
  logic rw;
  logic stb;
  logic stb2;
  logic four_line = 1'b1;
  logic [7:0] bus_in;
  logic [7:0] bus_out;
  logic oe;
  logic busy;
  logic [6:0] ptr;
  logic gsel;
  logic upper;
  logic [5:0] shift_off;
  logic don;
  logic con;
  logic bon;
  logic dark;
  lcdid_byte_t q;
  int bad_count = 0;
  int n_compared = 0;

  always #25 clk = ~clk;

  lcdid_decoder #(.HOME_CYC(40), .BLINK_CYC(20)) i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .register_select_i(rs), .read_not_write_i(rw),
    .strobe_i(stb), .second_strobe_i(stb2), .four_line_i(four_line),
    .parallel_bus_i(bus_in), .parallel_bus_o(bus_out), .parallel_bus_oe_o(oe),
    .busy_flag_o(busy), .address_pointer_o(ptr), .glyph_sel_o(gsel),
    .upper_pair_o(upper), .shift_offset_o(shift_off), .display_on_o(don),
    .cursor_on_o(con), .blink_on_o(bon), .blink_dark_o(dark)
  );

  lcdid_host i_host (
    .clk_i(clk), .bus_i(bus_out), .register_select_o(rs), .read_not_write_o(rw),
    .strobe_o(stb), .second_strobe_o(stb2), .bus_o(bus_in)
  );

  task automatic tally_and_finish();
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_eq(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic xfer(input logic r, input logic w, input lcdid_byte_t d);
    logic ok;
    i_host.cmd(r, w, d, q, ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] %0t busy never cleared", $time);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic r, input lcdid_byte_t d);
    xfer(r, 1'b0, d);
  endtask

  task automatic st();
    i_host.access(1'b0, 1'b1, 8'h00, q);
  endtask

  task automatic t_clear();
    wr(0, 8'h85);
    wr(0, 8'h01);
    st();
    `CHK(q[7], 1'b1)
    xfer(1, 1, 8'h00);
    `CHK(q, 8'h20)
    st();
    `CHK(q[6:0], 7'h01)
    wr(0, 8'h06);
    `CHK(busy, 1'b1)
    repeat (700) @(posedge clk);
    st();
    `CHK(q[7], 1'b1)
    `CHK(oe, 1'b0)
  endtask

  task automatic t_rw();
    wr(0, 8'h85);
    `CHK(gsel, 1'b0)
    wr(1, 8'h41);
    st();
    `CHK(q[6:0], 7'h06)
    wr(0, 8'h04);
    wr(1, 8'h42);
    st();
    `CHK(q[6:0], 7'h05)
    wr(0, 8'h86);
    xfer(1, 1, 8'h00);
    `CHK(q, 8'h42)
    st();
    `CHK(q[6:0], 7'h05)
    `CHK(shift_off, 6'h00)
    wr(0, 8'h48);
    `CHK(gsel, 1'b1)
    wr(1, 8'h1f);
    wr(0, 8'h48);
    xfer(1, 1, 8'h00);
    `CHK(q, 8'h1f)
  endtask

  task automatic t_entry();
    wr(0, 8'h90);
    wr(0, 8'h07);
    wr(1, 8'h55);
    `CHK(shift_off, 6'h01)
    xfer(1, 1, 8'h00);
    `CHK(shift_off, 6'h01)
    wr(0, 8'h05);
    wr(1, 8'h56);
    `CHK(shift_off, 6'h00)
    wr(0, 8'h06);
  endtask

  task automatic t_home();
    lcdid_byte_t sv;
    wr(0, 8'ha3);
    xfer(1, 1, 8'h00);
    sv = q;
    wr(0, 8'ha3);
    // save location around home, then restore
    wr(0, 8'h02);
    wr(0, 8'ha3);
    wr(1, sv);
    wr(0, 8'ha3);
    xfer(1, 1, 8'h00);
    `CHK(q, sv)
    wr(0, 8'h18);
    `CHK(shift_off, 6'h01)
    wr(0, 8'h03);
    // home repeated straight away, shift already zeroed by the first home
    wr(0, 8'h02);
    st();
    `CHK(q[6:0], 7'h00)
    `CHK(shift_off, 6'h00)
    wr(0, 8'h85);
    xfer(1, 1, 8'h00);
    `CHK(q, 8'h41)
  endtask

  task automatic t_ctrl();
    int tog;
    logic last;
    for (int v = 0; v < 8; v++)
    begin
      wr(0, 8'h08 | 8'(v));
      `CHK({don, con, bon}, v[2:0])
    end
    tog = 0;
    last = dark;
    repeat (100)
    begin
      @(posedge clk);
      #2;
      tog += (dark !== last);
      last = dark;
    end
    `CHK(tog >= 4 && tog <= 6, 1'b1)
    wr(0, 8'h08);
    wr(0, 8'h85);
    xfer(1, 1, 8'h00);
    `CHK(q, 8'h41)
    wr(0, 8'h0c);
  endtask

  task automatic t_cursor();
    wr(0, 8'ha7);
    wr(0, 8'h14);
    st();
    `CHK(q[6:0], 7'h40)
    wr(0, 8'h10);
    st();
    `CHK(q[6:0], 7'h27)
    wr(0, 8'he7);
    wr(0, 8'h14);
    st();
    `CHK(q[6:0], 7'h00)
    wr(0, 8'h1c);
    `CHK(shift_off, 6'h27)
    wr(0, 8'h18);
    `CHK(shift_off, 6'h00)
  endtask

  task automatic t_four();
    i_host.use_second = 1'b1;
    wr(0, 8'h85);
    wr(0, 8'h01);
    st();
    `CHK(q[6:0], 7'h00)
    `CHK(upper, 1'b1)
    four_line = 1'b0;
    wr(0, 8'h01);
    st();
    `CHK(upper, 1'b0)
    four_line = 1'b1;
    i_host.use_second = 1'b0;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    st();
    `CHK(q, 8'h00)
    t_clear();
    t_rw();
    t_entry();
    t_home();
    t_ctrl();
    t_cursor();
    t_four();
    tally_and_finish();
  end
endmodule // tb
